// [verilog/branch_defs.svh]
`ifndef BRANCH_DEFS_SVH
`define BRANCH_DEFS_SVH

// Instruction fields, counted with bit 0 as the least significant bit
`define LONG_OFS_HI 25
`define LONG_OFS_LO 2
`define COND_OFS_HI 15
`define COND_OFS_LO 2
`define OPT_HI 25
`define OPT_LO 21
`define SEL_HI 20
`define SEL_LO 16
`define ABS_BIT 1
`define LINK_BIT 0
`define SIGN_BIT 15

// Bits inside the five-bit branch_options field
`define OPT_IGNORE_COND 4
`define OPT_SENSE 3
`define OPT_NO_DEC 2
`define OPT_CTR_ZERO 1
`define OPT_HINT 0

// Address arithmetic
`define ADDR_STEP 32'h0000_0004
`define ALIGN_MASK 32'hffff_fffc
`define ZERO_WORD 32'h0000_0000
`define LOW_PAD 2'h0

// Register port indices and reset values
`define IDX_LINK 2'h0
`define IDX_COUNT 2'h1
`define IDX_STATUS 2'h2
`define IDX_STATS 2'h3
`define RST_LINK 32'h0000_0000
`define RST_COUNT 32'h0000_0000
`define RST_STAT 16'h0000
`define STAT_ONE 16'h0001
`define COUNT_STEP 32'h0000_0001
`define STATUS_PAD 27'h0000000

`endif

// [verilog/branch_pkg.sv]
package branch_pkg;

    // Branch form as classified by the decoder
    typedef enum logic [1:0] {
        KIND_DIRECT = 2'h0,
        KIND_COND = 2'h1,
        KIND_LINK = 2'h2,
        KIND_COUNT = 2'h3
    } kind_t;

    // Resolution state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT_REG = 3'h2,
        ST_UNRESOLVED = 3'h4
    } state_t;

endpackage

// [verilog/branch_calc_if.sv]
`timescale 1ns/1ps

// Operands in, target and sequential address out
interface branch_calc_if;
    logic [31:0] instr;
    branch_pkg::kind_t kind;
    logic [31:0] instrAddr;
    logic [31:0] linkVal;
    logic [31:0] countVal;
    logic [31:0] target;
    logic [31:0] seqAddr;

    modport core (
        output instr, kind, instrAddr, linkVal, countVal,
        input target, seqAddr
    );
    modport calc (
        input instr, kind, instrAddr, linkVal, countVal,
        output target, seqAddr
    );
endinterface

// [verilog/branch_target_calc.sv]
`timescale 1ns/1ps
`include "branch_defs.svh"

module branch_target_calc (
    branch_calc_if.calc bus
);
    logic [31:0] longDisp;
    logic [31:0] condDisp;
    logic [31:0] disp;
    logic [31:0] base;
    logic [31:0] raw;

    // Offsets padded with two zero bits, then sign-extended
    assign longDisp = {{6{bus.instr[`LONG_OFS_HI]}},
        bus.instr[`LONG_OFS_HI:`LONG_OFS_LO], `LOW_PAD}; // [RULE_09]
    assign condDisp = {{16{bus.instr[`COND_OFS_HI]}},
        bus.instr[`COND_OFS_HI:`COND_OFS_LO], `LOW_PAD}; // [RULE_10]

    // Absolute select drops the instruction address from the sum
    assign disp = (bus.kind == branch_pkg::KIND_DIRECT) ?
        longDisp : condDisp;
    assign base = bus.instr[`ABS_BIT] ? `ZERO_WORD :
        bus.instrAddr; // [RULE_13] [RULE_11] [RULE_12]

    // Register forms take the register; displacement forms the sum
    always_comb
    begin
        unique case (bus.kind)
            branch_pkg::KIND_LINK: raw = bus.linkVal; // [RULE_15]
            branch_pkg::KIND_COUNT: raw = bus.countVal; // [RULE_15]
            default: raw = base + disp; // [RULE_05]
        endcase
    end

    // Fetch is word based, so the two low bits never leave here
    assign bus.target = raw & `ALIGN_MASK; // [RULE_08]
    assign bus.seqAddr = (bus.instrAddr + `ADDR_STEP) & `ALIGN_MASK;
endmodule

// [verilog/branch_target_and_resolution.sv]
`timescale 1ns/1ps
`include "branch_defs.svh"

// Function
// RULE_01: Resolve at once when tested bit unlocked
// RULE_02: Interlocked branch uses static prediction
// RULE_03: Fetch predicted path, confirm when interlock clears
// RULE_04: Misprediction purges and fetches other path
// RULE_05: Displacement targets computed at decode time
// RULE_06: Register targets wait for register write
// RULE_07: Link written after target, taken or not
// RULE_08: Low two target bits ignored
// RULE_09: Long offset plus address for relative
// RULE_10: Short offset plus address when satisfied
// RULE_11: Long offset alone for absolute
// RULE_12: Short offset alone for conditional absolute
// RULE_13: Bit 30 selects absolute or relative
// RULE_14: Bit 31 requests link update
// RULE_15: Register target with low bits cleared
// RULE_16: Options pick sense, ignore, counter test
// RULE_17: Prediction from options, sign and hint
// RULE_18: Select field picks one of 32 flags
// RULE_19: Not satisfied means next sequential word
module branch_target_and_resolution (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic decodeValid,
    output logic decodeReady,
    input wire logic [31:0] instr,
    input wire branch_pkg::kind_t kind,
    input wire logic [31:0] instrAddr,
    input wire logic [31:0] condFlags,
    input wire logic [31:0] condPending,
    input wire logic linkBusy,
    input wire logic countBusy,
    input wire logic [1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic redirect,
    output logic [31:0] fetchAddr,
    output logic purge,
    output logic branchDone,
    output logic unresolved,
    output logic predictTaken
);
    branch_pkg::state_t state;
    branch_pkg::state_t next_state;
    branch_calc_if calcBus ();

    logic [31:0] returnLink;
    logic [31:0] loopCounter;
    logic [31:0] heldInstr;
    branch_pkg::kind_t heldKind;
    logic [31:0] heldAddr;
    logic [31:0] altAddr;
    logic [4:0] savedOpts;
    logic [4:0] savedSel;
    logic savedCtrOk;
    logic [15:0] hitCount;
    logic [15:0] missCount;

    logic [31:0] curInstr;
    branch_pkg::kind_t curKind;
    logic [31:0] curAddr;
    logic [4:0] opts;
    logic [4:0] sel;
    logic [31:0] nextCounter;
    logic decCounter;
    logic ctrOk;
    logic interlock;
    logic taken;
    logic guess;
    logic usesReg;
    logic regBusy;
    logic go;
    logic settle;
    logic actual;
    logic idle;
    logic [31:0] statusWord;

    // Flag number 0 is the most significant bit of the flag word
    function automatic logic flagAt(input logic [31:0] flags,
        input logic [4:0] idx);
        flagAt = flags[~idx];
    endfunction

    // Condition part of the options test
    function automatic logic condMet(input logic [4:0] o,
        input logic bit_);
        condMet = o[`OPT_IGNORE_COND] | (bit_ == o[`OPT_SENSE]);
    endfunction

    // Software write strobe aimed at one register index
    function automatic logic wrHit(input logic we, input logic [1:0] ad,
        input logic [1:0] idx);
        wrHit = we & (ad == idx);
    endfunction

    // Idle is the only state in which a new branch is looked at
    assign idle = (state == branch_pkg::ST_IDLE);

    // Decode stage holds the branch until accepted in idle
    assign curInstr = idle ? instr : heldInstr;
    assign curKind = idle ? kind : heldKind;
    assign curAddr = idle ? instrAddr : heldAddr;
    assign opts = curInstr[`OPT_HI:`OPT_LO];
    assign sel = curInstr[`SEL_HI:`SEL_LO]; // [RULE_18]

    // Target arithmetic lives in its own module
    assign calcBus.instr = curInstr;
    assign calcBus.kind = curKind;
    assign calcBus.instrAddr = curAddr;
    assign calcBus.linkVal = returnLink;
    assign calcBus.countVal = loopCounter;

    branch_target_calc calcUnit (
        .bus(calcBus.calc)
    );

    // Counter decrement and test; unconditional form never counts
    assign decCounter = (curKind != branch_pkg::KIND_DIRECT) &
        ~opts[`OPT_NO_DEC]; // [RULE_16]
    assign nextCounter = loopCounter - `COUNT_STEP;
    assign ctrOk = opts[`OPT_NO_DEC] |
        ((nextCounter != `ZERO_WORD) ^ opts[`OPT_CTR_ZERO]); // [RULE_16]

    // Scan of in-flight writers to the tested flag
    assign interlock = (curKind != branch_pkg::KIND_DIRECT) &
        ~opts[`OPT_IGNORE_COND] & flagAt(condPending, sel); // [RULE_01]

    // Outcome when the flag is already settled
    assign taken = (curKind == branch_pkg::KIND_DIRECT) |
        (ctrOk & condMet(opts, flagAt(condFlags, sel))); // [RULE_01]

    // Static guess from the encoding
    assign guess = ((opts[`OPT_IGNORE_COND] & opts[`OPT_NO_DEC]) |
        curInstr[`SIGN_BIT]) ^ opts[`OPT_HINT]; // [RULE_17]

    // Register targets need the register written first
    assign usesReg = (curKind == branch_pkg::KIND_LINK) |
        (curKind == branch_pkg::KIND_COUNT);
    assign regBusy = ((curKind == branch_pkg::KIND_LINK) & linkBusy) |
        ((curKind == branch_pkg::KIND_COUNT) & countBusy); // [RULE_06]

    // A branch is evaluated in idle or once its register is ready
    assign go = ((state == branch_pkg::ST_IDLE) & decodeValid &
        ~(usesReg & regBusy)) |
        ((state == branch_pkg::ST_WAIT_REG) & ~regBusy); // [RULE_06]

    // Unresolved branch settles when its flag is no longer pending
    assign settle = (state == branch_pkg::ST_UNRESOLVED) &
        ~flagAt(condPending, savedSel); // [RULE_03]
    assign actual = savedCtrOk &
        condMet(savedOpts, flagAt(condFlags, savedSel)); // [RULE_03]

    // Only one branch in flight; a second one waits at decode
    assign decodeReady = idle;
    assign unresolved = (state == branch_pkg::ST_UNRESOLVED);

    // Next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            branch_pkg::ST_IDLE:
            begin
                if (decodeValid & usesReg & regBusy)
                    next_state = branch_pkg::ST_WAIT_REG; // [RULE_06]
                else if (go & interlock)
                    next_state = branch_pkg::ST_UNRESOLVED; // [RULE_02]
            end
            branch_pkg::ST_WAIT_REG:
            begin
                if (go & interlock)
                    next_state = branch_pkg::ST_UNRESOLVED; // [RULE_02]
                else if (go)
                    next_state = branch_pkg::ST_IDLE;
            end
            branch_pkg::ST_UNRESOLVED:
            begin
                if (settle)
                    next_state = branch_pkg::ST_IDLE; // [RULE_03]
            end
            default: next_state = branch_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state <= branch_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // Capture the branch so it survives a register wait
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            heldInstr <= `ZERO_WORD;
            heldKind <= branch_pkg::KIND_DIRECT;
            heldAddr <= `ZERO_WORD;
        end
        else if ((state == branch_pkg::ST_IDLE) & decodeValid)
        begin
            heldInstr <= instr;
            heldKind <= kind;
            heldAddr <= instrAddr;
        end
    end

    // Facts kept for the later check of an unresolved branch
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            savedOpts <= 5'h00;
            savedSel <= 5'h00;
            savedCtrOk <= 1'b0;
            predictTaken <= 1'b0;
            altAddr <= `ZERO_WORD;
        end
        else if (go & interlock)
        begin
            savedOpts <= opts;
            savedSel <= sel;
            savedCtrOk <= ctrOk;
            predictTaken <= guess; // [RULE_02]
            altAddr <= guess ? calcBus.seqAddr : calcBus.target;
        end
    end

    // Fetch steering: resolved, predicted, or corrected path
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            redirect <= 1'b0;
            fetchAddr <= `ZERO_WORD;
        end
        else if (go & ~interlock)
        begin
            redirect <= 1'b1;
            fetchAddr <= taken ? calcBus.target :
                calcBus.seqAddr; // [RULE_01] [RULE_19]
        end
        else if (go)
        begin
            redirect <= 1'b1;
            fetchAddr <= guess ? calcBus.target :
                calcBus.seqAddr; // [RULE_02] [RULE_03]
        end
        else if (settle & (actual != predictTaken))
        begin
            redirect <= 1'b1;
            fetchAddr <= altAddr; // [RULE_04]
        end
        else
            redirect <= 1'b0;
    end

    // Purge on a wrong guess; done pulse on every completion
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            purge <= 1'b0;
            branchDone <= 1'b0;
        end
        else
        begin
            purge <= settle & (actual != predictTaken); // [RULE_04]
            branchDone <= (go & ~interlock) | settle; // [RULE_03]
        end
    end

    // Link gets the next address after the target used the old value
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            returnLink <= `RST_LINK;
        else if (go & curInstr[`LINK_BIT])
            returnLink <= calcBus.seqAddr; // [RULE_07] [RULE_14]
        else if (wrHit(regWrite, regAddr, `IDX_LINK))
            returnLink <= regWdata;
    end

    // Counter decrements once, when the branch is evaluated
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            loopCounter <= `RST_COUNT;
        else if (go & decCounter)
            loopCounter <= nextCounter; // [RULE_16]
        else if (wrHit(regWrite, regAddr, `IDX_COUNT))
            loopCounter <= regWdata;
    end

    // Prediction statistics; they wrap rather than saturate
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hitCount <= `RST_STAT;
            missCount <= `RST_STAT;
        end
        else if (wrHit(regWrite, regAddr, `IDX_STATS))
        begin
            hitCount <= `RST_STAT;
            missCount <= `RST_STAT;
        end
        else if (settle & (actual == predictTaken))
            hitCount <= hitCount + `STAT_ONE;
        else if (settle)
            missCount <= missCount + `STAT_ONE;
    end

    // Status word: guess, link wait and the one-hot state, zero above
    // Link busy is shown live so software can see why a link branch waits; count busy is not shown
    assign statusWord = {`STATUS_PAD, predictTaken, linkBusy, state};

    // Read data appear in the cycle after the strobe only
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= `ZERO_WORD;
        else if (regRead)
        begin
            unique case (regAddr)
                `IDX_LINK: regRdata <= returnLink;
                `IDX_COUNT: regRdata <= loopCounter;
                `IDX_STATUS: regRdata <= statusWord;
                `IDX_STATS: regRdata <= {hitCount, missCount};
            endcase
        end
        else
            regRdata <= `ZERO_WORD;
    end
endmodule

// [verif/exec_units_model.sv]
`timescale 1ns/1ps

// Execution units: an in-flight writer holds one flag pending, then writes
module exec_units_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [31:0] word,
    input wire logic [4:0] sel,
    input wire logic [3:0] len,
    output logic [31:0] condFlags,
    output logic [31:0] condPending
);
    logic [3:0] left;
    logic [31:0] bitMask;

    // While pending the flag shows the wrong value, never a kind one
    assign bitMask = (len != 4'h0) ? (32'h1 << (31 - sel)) : 32'h0;

    // Load the flag word, then release the interlock after len edges
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left <= 4'h0;
            condFlags <= 32'h0;
            condPending <= 32'h0;
        end
        else if (go)
        begin
            left <= len;
            condFlags <= word ^ bitMask;
            condPending <= bitMask;
        end
        else if (left == 4'h1)
        begin
            left <= 4'h0;
            condFlags <= condFlags ^ condPending;
            condPending <= 32'h0;
        end
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
endmodule

// [verif/branch_monitor.sv]
`timescale 1ns/1ps

// Port-level timing and target checks on the branch unit
module branch_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic decodeValid,
    input wire logic decodeReady,
    input wire logic [31:0] instr,
    input wire branch_pkg::kind_t kind,
    input wire logic [31:0] instrAddr,
    input wire logic [31:0] condFlags,
    input wire logic [31:0] condPending,
    input wire logic linkBusy,
    input wire logic redirect,
    input wire logic [31:0] fetchAddr,
    input wire logic purge,
    input wire logic branchDone,
    input wire logic unresolved,
    input wire logic predictTaken
);
    logic acc;
    logic cond;
    logic [4:0] opt;
    logic [31:0] rel;
    logic [31:0] dTgt;
    logic [31:0] cNext;
    logic pred;
    logic wrong;
    logic [4:0] hSel;
    logic [1:0] hOpt;

    // Expected targets worked out from the offered word
    assign acc = decodeValid && decodeReady;
    assign cond = acc && kind == branch_pkg::KIND_COND && opt[2];
    assign opt = instr[25:21];
    assign rel = instr[1] ? 32'h0 : instrAddr;
    assign dTgt = {{6{instr[25]}}, instr[25:2], 2'h0} + rel;
    assign cNext = (opt[4] || condFlags[31 - instr[20:16]] == opt[3])
        ? {{16{instr[15]}}, instr[15:2], 2'h0} + rel : instrAddr + 32'h4;
    assign pred = ((opt[4] & opt[2]) | instr[15]) ^ opt[0];
    assign wrong = (condFlags[31 - hSel] == hOpt[1]) != predictTaken;

    // Remember which flag an unresolved branch waits on
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hSel <= 5'h0;
            hOpt <= 2'h0;
        end
        else if (acc)
        begin
            hSel <= instr[20:16];
            hOpt <= {opt[3], opt[2]};
        end
    end

    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_direct;
        acc && kind == branch_pkg::KIND_DIRECT |=> redirect && branchDone
            && fetchAddr == ($past(dTgt) & 32'hffff_fffc);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct target wrong");
    property p_now;
        cond && !condPending[31 - instr[20:16]] |=> branchDone
            && !unresolved && fetchAddr == ($past(cNext) & 32'hffff_fffc);
    endproperty
    a_now: assert property (p_now)
        else $error("resolved branch wrong");
    property p_lock;
        cond && !opt[4] && condPending[31 - instr[20:16]]
            |=> unresolved && redirect && predictTaken == $past(pred);
    endproperty
    a_lock: assert property (p_lock)
        else $error("interlock guess wrong");
    property p_hold;
        unresolved && condPending[31 - hSel] |=> !branchDone && !redirect;
    endproperty
    a_hold: assert property (p_hold)
        else $error("resolved while pending");
    property p_confirm;
        unresolved && hOpt[0] && !condPending[31 - hSel]
            |=> branchDone && purge == $past(wrong);
    endproperty
    a_confirm: assert property (p_confirm)
        else $error("confirm or purge wrong");
    property p_purge;
        purge |-> redirect && branchDone && !unresolved;
    endproperty
    a_purge: assert property (p_purge)
        else $error("purge without refetch");
    property p_align;
        redirect |-> fetchAddr[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align)
        else $error("fetch not aligned");
    property p_wait;
        acc && kind == branch_pkg::KIND_LINK && linkBusy
            |=> !redirect && !decodeReady;
    endproperty
    a_wait: assert property (p_wait)
        else $error("link branch did not wait");
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
    n_mismatch++; $display("Error %0t: %h vs %h", $time, g, x); end end

module testbench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic decodeValid = 1'b0;
    logic [31:0] instr = 32'h0;
    branch_pkg::kind_t kind = branch_pkg::KIND_DIRECT;
    logic [31:0] instrAddr = 32'h0;
    logic linkBusy = 1'b0;
    logic countBusy = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic go = 1'b0;
    logic [31:0] word = 32'h0;
    logic [4:0] sel = 5'h0;
    logic [3:0] len = 4'h0;
    logic decodeReady, redirect, purge, branchDone, unresolved, predictTaken;
    logic [31:0] regRdata, fetchAddr, condFlags, condPending;
    logic [31:0] lk, ct, d, a, i, w, e, st;
    logic p, t;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [4:0] opts [9] = '{5'h04, 5'h0c, 5'h14, 5'h00, 5'h02, 5'h08,
        5'h0a, 5'h10, 5'h12};
    branch_pkg::kind_t k;

    branch_target_and_resolution dut_u (.mclk, .rst_n, .decodeValid,
        .decodeReady, .instr, .kind, .instrAddr, .condFlags, .condPending,
        .linkBusy, .countBusy, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .redirect, .fetchAddr, .purge, .branchDone, .unresolved,
        .predictTaken);
    exec_units_model part_u (.mclk, .rst_n, .go, .word, .sel, .len,
        .condFlags, .condPending);

    // Clock, and a cycle ceiling so a hang still ends in the report
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    task wrap_up;
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Expected target: old register value for register forms
    function automatic logic [31:0] tgt(branch_pkg::kind_t m,
        logic [31:0] iw, logic [31:0] ad);
        logic [31:0] o;
        o = {{16{iw[15]}}, iw[15:2], 2'h0};
        if (m == branch_pkg::KIND_DIRECT)
            o = {{6{iw[25]}}, iw[25:2], 2'h0};
        if (!iw[1])
            o = o + ad;
        if (m == branch_pkg::KIND_LINK)
            o = lk;
        if (m == branch_pkg::KIND_COUNT)
            o = ct;
        return o & 32'hffff_fffc;
    endfunction

    // Counter must already hold its decremented value
    function automatic logic taken(logic [31:0] iw, logic f);
        return (iw[23] || (ct == 32'h0) == iw[22]) && (iw[25] || f == iw[24]);
    endfunction

    task wr(logic [1:0] ad, logic [31:0] v);
        @(posedge mclk);
        regAddr <= ad;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task rd(logic [1:0] ad, output logic [31:0] v);
        @(posedge mclk);
        regAddr <= ad;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        v = regRdata;
    endtask

    task setf(logic [31:0] fw, logic [4:0] s, logic [3:0] n);
        @(posedge mclk);
        word <= fw;
        sel <= s;
        len <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask

    // Offer one branch; the idle unit takes it at the next edge
    task br(logic [31:0] iw, logic [31:0] ad);
        @(posedge mclk);
        kind <= k;
        instr <= iw;
        instrAddr <= ad;
        decodeValid <= 1'b1;
        @(posedge mclk);
        decodeValid <= 1'b0;
        @(negedge mclk);
    endtask

    task wait_done;
        for (int n = 0; n < 20 && branchDone !== 1'b1; n++)
            @(negedge mclk);
        `CHK(branchDone, 1'b1)
    endtask

    initial
    begin
        void'($urandom(31835));
        lk = 32'h0;
        ct = 32'h0;
        st = 32'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(2'h0, d);
        `CHK(d, 32'h0)
        rd(2'h2, d);
        `CHK(d, 32'h1)
        $display("Test reset done");
        k = branch_pkg::KIND_DIRECT;
        for (int n = 0; n < 24; n++)
        begin
            a = $urandom & 32'hffff_fffc;
            i = $urandom;
            if (n == 0)
                i[25:2] = 24'h800000;
            e = tgt(k, i, a);
            br(i, a);
            `CHK(fetchAddr, e)
            `CHK(branchDone, 1'b1)
            if (i[0])
                lk = a + 32'h4;
            rd(2'h0, d);
            `CHK(d, lk)
        end
        $display("Test direct done");
        k = branch_pkg::KIND_COND;
        for (int n = 0; n < 27; n++)
        begin
            ct = $urandom % 3;
            wr(2'h1, ct);
            i = $urandom;
            i[25:21] = opts[n % 9];
            w = $urandom;
            setf(w, 5'h0, 4'h0);
            a = $urandom & 32'hffff_fffc;
            if (!i[23])
                ct = ct - 32'h1;
            e = taken(i, w[31 - i[20:16]]) ? tgt(k, i, a) : a + 32'h4;
            br(i, a);
            `CHK(fetchAddr, e)
            `CHK(unresolved, 1'b0)
            rd(2'h1, d);
            `CHK(d, ct)
            if (i[0])
                lk = a + 32'h4;
        end
        $display("Test resolved done");
        for (int n = 0; n < 12; n++)
        begin
            i = $urandom;
            i[25:21] = opts[n % 2] | {4'h0, n[1]};
            w = $urandom;
            a = $urandom & 32'hffff_fffc;
            setf(w, i[20:16], 4'h4 + 4'($urandom % 8));
            p = ((i[25] & i[23]) | i[15]) ^ i[21];
            t = taken(i, w[31 - i[20:16]]);
            e = tgt(k, i, a);
            br(i, a);
            `CHK(unresolved, 1'b1)
            `CHK(predictTaken, p)
            `CHK(fetchAddr, p ? e : a + 32'h4)
            wait_done;
            `CHK(purge, p != t)
            `CHK(fetchAddr, t ? e : a + 32'h4)
            st = st + ((p == t) ? 32'h1_0000 : 32'h1);
            if (i[0])
                lk = a + 32'h4;
        end
        $display("Test interlock done");
        for (int n = 0; n < 2; n++)
        begin
            k = n ? branch_pkg::KIND_COUNT : branch_pkg::KIND_LINK;
            @(posedge mclk);
            linkBusy <= !n;
            countBusy <= n[0];
            d = $urandom;
            wr(2'(n), d);
            if (n)
                ct = d;
            else
                lk = d;
            i = ($urandom & 32'hfc1f_0001) | 32'h0280_0000;
            a = $urandom & 32'hffff_fffc;
            e = tgt(k, i, a);
            br(i, a);
            `CHK(decodeReady, 1'b0)
            repeat (3) @(posedge mclk);
            linkBusy <= 1'b0;
            countBusy <= 1'b0;
            wait_done;
            `CHK(fetchAddr, e)
            if (i[0])
                lk = a + 32'h4;
            rd(2'h0, d);
            `CHK(d, lk)
        end
        $display("Test register form done");
        rd(2'h3, d);
        `CHK(d, st)
        wr(2'h3, 32'h0);
        rd(2'h3, d);
        `CHK(d, 32'h0)
        $display("Test statistics done");
        wrap_up;
    end
endmodule

bind branch_target_and_resolution branch_monitor mon_u (.mclk, .rst_n,
    .decodeValid, .decodeReady, .instr, .kind, .instrAddr, .condFlags,
    .condPending, .linkBusy, .redirect, .fetchAddr, .purge, .branchDone,
    .unresolved, .predictTaken);
